// File: inc/lvsd_pkg.sv
// ****************************************
// shared constants for both link ends
// ****************************************
package lvsd_pkg;
  localparam int CLK_MHZ        = 100;  // system clock rate
  localparam int CK_HALF        = 4;    // system cycles per half link clock
  // long waits in their own units, then in system cycles
  localparam int RST_PU_US      = 200;  // reset hold after power-up
  localparam int RST_PU_CYC     = RST_PU_US * CLK_MHZ;
  localparam int RST_SP_NS      = 100;  // reset hold with stable power
  localparam int RST_SP_CYC     = (RST_SP_NS * CLK_MHZ + 999) / 1000;
  localparam int CKE_LEAD_NS    = 10;   // cke low ahead of reset release
  localparam int CKE_LEAD_CYC   = (CKE_LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int CKE_WAIT_US    = 500;  // reset release to cke high
  localparam int CKE_WAIT_CYC   = CKE_WAIT_US * CLK_MHZ;
  // waits counted in link clocks
  localparam int CLK_STAB_TCK   = 5;    // stable clock before cke
  localparam int XS_TCK         = 8;    // self refresh exit, plain default
  localparam int XPR_TCK        = (XS_TCK > 5) ? XS_TCK : 5;
  localparam int MRD_TCK        = 4;    // mode write spacing, plain default
  localparam int MOD_TCK        = 12;   // mode to command delay, plain default
  localparam int DLLK_TCK       = 512;  // dll lock time, plain default
  localparam int ZQINIT_TCK     = 512;  // initial cal time, plain default
  localparam int CAL_TCK        = (DLLK_TCK > ZQINIT_TCK) ? DLLK_TCK : ZQINIT_TCK;
  // widths
  localparam int WAIT_W         = 20;
  localparam int TCK_W          = 10;
  localparam int ROW_W          = 14;
  localparam int BANK_W         = 3;
  localparam int NBANKS         = 8;
  // address bit positions
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int CHOP_SEL_BIT   = 12;
  localparam int DLL_RST_BIT    = 8;
  localparam int DLL_OFF_BIT    = 0;
  localparam int BURST_ILV_BIT  = 3;
  // mode register numbers on bank_select
  localparam logic [2:0] MR_TWO   = 3'h2;
  localparam logic [2:0] MR_THREE = 3'h3;
  localparam logic [2:0] MR_ONE   = 3'h1;
  localparam logic [2:0] MR_ZERO  = 3'h0;
  // burst length field of mode register zero
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  // {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_MRS = 4'b0000, CMD_REF = 4'b0001, CMD_PRE = 4'b0010, CMD_ACT  = 4'b0011,
    CMD_WR  = 4'b0100, CMD_RD  = 4'b0101, CMD_ZQ  = 4'b0110, CMD_NOP  = 4'b0111,
    CMD_DES = 4'b1111
  } lvsd_cmd_t;
  typedef enum logic [1:0] {
    OP_ACT = 2'b00, OP_RD = 2'b01, OP_WR = 2'b10, OP_REF = 2'b11
  } lvsd_op_t;
endpackage

// File: inc/lvsd_if.sv
// ****************************************
// link between controller and memory
// ****************************************
interface lvsd_if;
  logic        reset_n;              // memory reset, active low
  logic        ck;                   // link clock from controller
  logic        cke;                  // clock enable
  logic [3:0]  cmd_n;                // cs_n ras_n cas_n we_n
  logic [2:0]  bank_select;          // bank or mode register number
  logic [13:0] row_col_address;      // row, column or mode value
  logic        termination_ctrl_in;  // termination control
  logic        term_hiz;             // memory termination held off
  modport ctrl (output reset_n, ck, cke, cmd_n, bank_select, row_col_address,
                termination_ctrl_in, input term_hiz);
  modport dev (input reset_n, ck, cke, cmd_n, bank_select, row_col_address,
               termination_ctrl_in, output term_hiz);
endinterface

// File: logic/lvsd_dev.sv
// ****************************************
// memory end of the link
// ****************************************
module lvsd_dev (
  // clock and reset
  input  logic                    clock,
  input  logic                    rst_n,
  // link
  lvsd_if.dev                     mem,
  // status
  output logic                    dev_ready,
  output logic                    dll_on,
  output logic [7:0]              open_banks,
  // burst beats
  output logic                    burst_active,
  output logic                    burst_write,
  output logic [2:0]              burst_bank,
  output logic [13:0]             burst_row,
  output logic [13:0]             burst_col
);
  import lvsd_pkg::*;

  localparam int SYNC_W = 3 + 4 + BANK_W + ROW_W;

  logic [SYNC_W-1:0] s1_q, s2_q;            // two stage pin synchroniser
  logic              l_rst_n, l_ck, l_cke;  // synchronised pins
  logic [3:0]        l_cmd;
  logic [2:0]        l_ba;
  logic [13:0]       l_addr;
  logic              ck_prev_q;             // for edge finding
  logic              rise, edge_any, cmd_ok, hard_clr;
  logic              cke_seen_q;            // cke registered since reset
  logic              term_hiz_q;
  logic [13:0]       mr_q [4];              // mode registers
  logic [7:0]        open_q;                // open bank flags
  logic [13:0]       row_q [NBANKS];        // open row per bank
  logic [TCK_W-1:0]  dll_cnt_q, cal_cnt_q;  // lock and cal countdown
  logic              zq_seen_q, ready_q, dll_on_q;
  logic              act_q, wr_q, len8_q, ilv_q, close_q;
  logic [2:0]        bank_q, beat_q;
  logic [13:0]       start_q, col_q;
  logic [13:0]       brow_q;                // row of the running burst
  logic [13:0]       col_start;             // start column, flag bits cleared
  logic              burst_end;

  // ****************************************
  // pin sampling and edge finding
  // ****************************************
  // reset, clock, cke, command, bank and address share one delay so command and clock stay aligned
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {mem.reset_n, mem.ck, mem.cke, mem.cmd_n, mem.bank_select, mem.row_col_address};
      s2_q <= s1_q;
    end
  end
  assign {l_rst_n, l_ck, l_cke, l_cmd, l_ba, l_addr} = s2_q;

  always_ff @(posedge clock) begin
    if (!rst_n) ck_prev_q <= 1'b0;
    else        ck_prev_q <= l_ck;
  end
  assign rise      = l_ck & ~ck_prev_q;
  assign edge_any  = l_ck ^ ck_prev_q;  // every half clock is one beat
  // pin reset acts at once, without waiting for a link clock edge
  assign hard_clr  = !rst_n || !l_rst_n;
  assign cmd_ok    = rise && l_cke && cke_seen_q;
  assign burst_end = act_q && edge_any && (beat_q == (len8_q ? 3'h7 : 3'h3));
  // close and chop bits are flags, not part of the column
  assign col_start = l_addr & ~((14'h1 << AUTO_CLOSE_BIT) | (14'h1 << CHOP_SEL_BIT));

  // ****************************************
  // clock enable and termination
  // ****************************************
  always_ff @(posedge clock) begin
    if (hard_clr) begin
      cke_seen_q <= 1'b0;
      term_hiz_q <= 1'b1;
    end else begin
      if (rise && l_cke) cke_seen_q <= 1'b1;
      term_hiz_q <= !cke_seen_q;
    end
  end

  // mode registers, dll and calibration timers
  always_ff @(posedge clock) begin
    if (hard_clr) begin
      for (int i = 0; i < 4; i++) mr_q[i] <= '0;  // contents lost on reset
      dll_cnt_q <= '0;
      cal_cnt_q <= '0;
      zq_seen_q <= 1'b0;
      dll_on_q  <= 1'b0;
      ready_q   <= 1'b0;
    end else begin
      if (rise && dll_cnt_q != '0) dll_cnt_q <= dll_cnt_q - 1'b1;
      if (rise && cal_cnt_q != '0) cal_cnt_q <= cal_cnt_q - 1'b1;
      if (cmd_ok && l_cmd == CMD_MRS && !l_ba[2]) begin
        mr_q[l_ba[1:0]] <= l_addr;
        if (l_ba == MR_ONE) dll_on_q <= !l_addr[DLL_OFF_BIT];
        if (l_ba == MR_ZERO && l_addr[DLL_RST_BIT]) dll_cnt_q <= TCK_W'(DLLK_TCK);
      end
      if (cmd_ok && l_cmd == CMD_ZQ) begin
        cal_cnt_q <= TCK_W'(ZQINIT_TCK);
        zq_seen_q <= 1'b1;
      end
      // ready once cke and the calibration command have been seen and the lock and cal countdowns are zero
      ready_q <= cke_seen_q && zq_seen_q && dll_cnt_q == '0 && cal_cnt_q == '0;
    end
  end

  // ****************************************
  // banks and rows
  // ****************************************
  always_ff @(posedge clock) begin
    if (hard_clr) begin
      open_q <= '0;
      for (int i = 0; i < NBANKS; i++) row_q[i] <= '0;
    end else begin
      if (cmd_ok && l_cmd == CMD_ACT) begin
        open_q[l_ba] <= 1'b1;
        row_q[l_ba]  <= l_addr;
      end else if (cmd_ok && l_cmd == CMD_PRE) begin
        if (l_addr[AUTO_CLOSE_BIT]) open_q <= '0;
        else                        open_q[l_ba] <= 1'b0;
      end
      if (burst_end && close_q) open_q[bank_q] <= 1'b0;
    end
  end

  // column of a beat, sequential or interleaved
  function automatic logic [2:0] beat_col(input logic [2:0] s, input logic [2:0] b,
                                          input logic ilv);
    if (ilv) beat_col = s ^ b;
    else     beat_col = {s[2] ^ b[2], 2'(s[1:0] + b[1:0])};
  endfunction

  // ****************************************
  // bursts
  // ****************************************
  // eight beats per access, four when chopped, two per link clock
  always_ff @(posedge clock) begin
    if (hard_clr) begin
      act_q   <= 1'b0;
      wr_q    <= 1'b0;
      len8_q  <= 1'b0;
      ilv_q   <= 1'b0;
      close_q <= 1'b0;
      bank_q  <= '0;
      beat_q  <= '0;
      start_q <= '0;
      col_q   <= '0;
      brow_q  <= '0;
    end else if (cmd_ok && (l_cmd == CMD_RD || l_cmd == CMD_WR)) begin
      act_q   <= 1'b1;
      wr_q    <= (l_cmd == CMD_WR);
      bank_q  <= l_ba;
      brow_q  <= row_q[l_ba];
      beat_q  <= '0;
      close_q <= l_addr[AUTO_CLOSE_BIT];
      ilv_q   <= mr_q[0][BURST_ILV_BIT];
      unique case (mr_q[0][1:0])
        BL_FIX8: len8_q <= 1'b1;
        BL_OTF:  len8_q <= l_addr[CHOP_SEL_BIT];
        default: len8_q <= 1'b0;
      endcase
      start_q <= col_start;
      col_q   <= col_start;
    end else if (act_q && edge_any) begin
      if (burst_end) act_q <= 1'b0;
      beat_q <= beat_q + 3'h1;
      col_q  <= {start_q[13:3], beat_col(start_q[2:0], beat_q + 3'h1, ilv_q)};
    end
  end

  assign mem.term_hiz = term_hiz_q;
  assign dev_ready    = ready_q;
  assign dll_on       = dll_on_q;
  assign open_banks   = open_q;
  assign burst_active = act_q;
  assign burst_write  = wr_q;
  assign burst_bank   = bank_q;
  assign burst_row    = brow_q;
  assign burst_col    = col_q;
endmodule // lvsd_dev

// File: logic/lvsd_ctrl.sv
// How it works
// - memory has eight banks, eightfold prefetch
// - one access is eight half-clock beats, four when chopped
// - bursts run eight beats or four chopped
// - activate carries bank and fourteen-bit row
// - column, auto close bit, chop bit
// - power-up reset held at least 200 us
// - cke low 10 ns before reset release
// - wait 500 us from release to cke
// - link clock runs five clocks before cke
// - nop registered before cke rises
// - cke stays high through initialisation
// - memory termination off until cke seen
// - termination control held low during init
// - wait reset exit time before mode writes
// - mode writes in order two three one zero
// - dll enabled, then dll restart
// - long calibration, then lock and cal wait
// - only nop between mode writes and calibration
// - stable power reset held 100 ns
// - stable power reset reruns whole sequence
// - reset pin clears memory at once
// - mode writes spaced by write spacing
// - mode to command delay before commands
module lvsd_ctrl #(
  parameter int unsigned RST_PU_CYCLES   = lvsd_pkg::RST_PU_CYC,
  parameter int unsigned CKE_WAIT_CYCLES = lvsd_pkg::CKE_WAIT_CYC
) (
  // clock and reset
  input  logic                    clock,
  input  logic                    rst_n,
  // link
  lvsd_if.ctrl                    mem,
  // mode values and controls
  input  logic                    soft_reset,
  input  logic [13:0]             mr0_val,
  input  logic [13:0]             mr1_val,
  input  logic [13:0]             mr2_val,
  input  logic [13:0]             mr3_val,
  input  logic                    term_on,
  // user orders
  input  logic                    req_valid,
  input  lvsd_pkg::lvsd_op_t      req_op,
  input  logic [2:0]              req_bank,
  input  logic [13:0]             req_addr,
  input  logic                    req_auto_close,
  input  logic                    req_chop,
  // status
  output logic                    req_ready,
  output logic                    init_done
);
  import lvsd_pkg::*;

  typedef enum logic [3:0] {
    ST_RST_HOLD = 4'b0000,  // memory reset asserted
    ST_CKE_LOW  = 4'b0001,  // reset released, cke low
    ST_XPR      = 4'b0010,  // reset exit wait
    ST_MRS      = 4'b0011,  // mode register writes
    ST_LONG_IMPEDANCE_CAL_CMD     = 4'b0100,  // calibration command
    ST_CAL      = 4'b0101,  // lock and calibration wait
    ST_READY    = 4'b0110   // normal orders
  } lvsd_state_t;

  lvsd_state_t        state_q;
  logic [1:0]         ck_cnt_q;      // divider count
  logic               ck_q;          // link clock
  logic               fall;          // link clock about to fall
  logic [WAIT_W-1:0]  wait_q;        // system cycle countdown
  logic [TCK_W-1:0]   tck_q;         // link clock countdown
  logic [1:0]         mr_idx_q;      // which mode write is next
  logic               reset_n_q, cke_q, term_q, done_q, ready_q, pend_q;
  lvsd_cmd_t          cmd_q;
  logic [2:0]         ba_q;
  logic [13:0]        addr_q;
  logic [2:0]         mr_ba;         // bank code of next mode write
  logic [13:0]        mr_addr;       // value of next mode write
  lvsd_op_t           op_q;          // latched order
  logic [2:0]         rbank_q;
  logic [13:0]        raddr_q;

  // ****************************************
  // link clock divider
  // ****************************************
  // runs always so the clock is stable long before cke rises
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ck_cnt_q <= '0;
      ck_q     <= 1'b0;
    end else if (ck_cnt_q == 2'(CK_HALF - 1)) begin
      ck_cnt_q <= '0;
      ck_q     <= !ck_q;
    end else begin
      ck_cnt_q <= ck_cnt_q + 2'h1;
    end
  end
  // commands change on the falling edge, memory takes them on the rising
  assign fall = (ck_cnt_q == 2'(CK_HALF - 1)) && ck_q;

  // ****************************************
  // mode write selection
  // ****************************************
  always_comb begin
    unique case (mr_idx_q)
      2'h0: begin mr_ba = MR_TWO;   mr_addr = mr2_val; end
      2'h1: begin mr_ba = MR_THREE; mr_addr = mr3_val; end
      2'h2: begin                                           // dll enabled
        mr_ba   = MR_ONE;
        mr_addr = mr1_val & ~(14'h1 << DLL_OFF_BIT);
      end
      2'h3: begin                                           // dll restart
        mr_ba   = MR_ZERO;
        mr_addr = mr0_val | (14'h1 << DLL_RST_BIT);
      end
    endcase
  end

  // ****************************************
  // initialisation sequencer
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q   <= ST_RST_HOLD;
      wait_q    <= WAIT_W'(RST_PU_CYCLES);
      tck_q     <= '0;
      mr_idx_q  <= '0;
      reset_n_q <= 1'b0;
      cke_q     <= 1'b0;
      cmd_q     <= CMD_NOP;
      ba_q      <= '0;
      addr_q    <= '0;
      done_q    <= 1'b0;
      ready_q   <= 1'b0;
      pend_q    <= 1'b0;
      op_q      <= OP_ACT;
      rbank_q   <= '0;
      raddr_q   <= '0;
    end else if (soft_reset) begin
      // cke drops with reset, so it leads the release by the whole hold
      state_q   <= ST_RST_HOLD;
      wait_q    <= WAIT_W'(RST_SP_CYC);
      reset_n_q <= 1'b0;
      cke_q     <= 1'b0;
      cmd_q     <= CMD_NOP;
      mr_idx_q  <= '0;
      done_q    <= 1'b0;
      ready_q   <= 1'b0;
      pend_q    <= 1'b0;
    end else begin
      // a command lives one link clock, then nop
      if (fall) cmd_q <= CMD_NOP;
      if (fall && tck_q != '0) tck_q <= tck_q - 1'b1;
      unique case (state_q)
        ST_RST_HOLD: begin
          if (wait_q == '0 && CKE_LEAD_CYC <= RST_SP_CYC) begin
            reset_n_q <= 1'b1;
            wait_q    <= WAIT_W'(CKE_WAIT_CYCLES);
            tck_q     <= TCK_W'(CLK_STAB_TCK);
            state_q   <= ST_CKE_LOW;
          end else begin
            wait_q <= wait_q - 1'b1;
          end
        end
        ST_CKE_LOW: begin
          if (wait_q != '0) begin
            wait_q <= wait_q - 1'b1;
          end else if (fall && tck_q == '0) begin
            cke_q   <= 1'b1;
            tck_q   <= TCK_W'(XPR_TCK);
            state_q <= ST_XPR;
          end
        end
        ST_XPR: begin
          if (fall && tck_q == '0) state_q <= ST_MRS;
        end
        ST_MRS: begin
          if (fall && tck_q == '0) begin
            cmd_q    <= CMD_MRS;
            ba_q     <= mr_ba;
            addr_q   <= mr_addr;
            mr_idx_q <= mr_idx_q + 2'h1;
            if (mr_idx_q == 2'h3) begin
              tck_q   <= TCK_W'(MOD_TCK);
              state_q <= ST_LONG_IMPEDANCE_CAL_CMD;
            end else begin
              tck_q   <= TCK_W'(MRD_TCK);
            end
          end
        end
        ST_LONG_IMPEDANCE_CAL_CMD: begin
          if (fall && tck_q == '0) begin
            cmd_q   <= CMD_ZQ;
            ba_q    <= '0;
            addr_q  <= 14'h1 << AUTO_CLOSE_BIT;             // long form
            tck_q   <= TCK_W'(CAL_TCK);
            state_q <= ST_CAL;
          end
        end
        ST_CAL: begin
          if (fall && tck_q == '0) begin
            done_q  <= 1'b1;
            ready_q <= 1'b1;
            state_q <= ST_READY;
          end
        end
        ST_READY: begin
          if (req_valid && ready_q) begin
            ready_q <= 1'b0;
            pend_q  <= 1'b1;
            op_q    <= req_op;
            rbank_q <= req_bank;
            raddr_q <= req_addr;                            // a row keeps all bits
            if (req_op == OP_RD || req_op == OP_WR) begin
              raddr_q[AUTO_CLOSE_BIT] <= req_auto_close;
              raddr_q[CHOP_SEL_BIT]   <= !req_chop;         // low chops to four
            end
          end else if (fall && pend_q) begin
            pend_q  <= 1'b0;
            ready_q <= 1'b1;
            ba_q    <= rbank_q;
            addr_q  <= raddr_q;
            unique case (op_q)
              OP_ACT: cmd_q <= CMD_ACT;
              OP_RD:  cmd_q <= CMD_RD;
              OP_WR:  cmd_q <= CMD_WR;
              OP_REF: cmd_q <= CMD_REF;
            endcase
          end
        end
        default: state_q <= ST_RST_HOLD;
      endcase
    end
  end

  // ****************************************
  // termination control
  // ****************************************
  // held low through init so nominal termination may be enabled
  always_ff @(posedge clock) begin
    if (!rst_n) term_q <= 1'b0;
    else        term_q <= done_q && term_on;
  end

  assign mem.reset_n             = reset_n_q;
  assign mem.ck                  = ck_q;
  assign mem.cke                 = cke_q;
  assign mem.cmd_n               = cmd_q;
  assign mem.bank_select         = ba_q;
  assign mem.row_col_address     = addr_q;
  assign mem.termination_ctrl_in = term_q;
  assign req_ready               = ready_q;
  assign init_done               = done_q;
endmodule // lvsd_ctrl

// File: test/lvsd_properties.sv
// ****************************************
// link checks, both ends
// ****************************************
module lvsd_properties
  import lvsd_pkg::*;
#(
  parameter int CKE_WAIT_CYCLES = CKE_WAIT_CYC  // must match the controller
) (
  // clock and reset
  input logic        clock,
  input logic        rst_n,
  // link
  input logic        reset_n,
  input logic        ck,
  input logic        cke,
  input logic [3:0]  cmd_n,
  input logic [2:0]  bank_select,
  input logic [13:0] row_col_address,
  input logic        termination_ctrl_in,
  input logic        term_hiz
);
  logic [19:0] low_q;   // cycles with memory reset low
  logic [19:0] wait_q;  // cycles since memory reset high
  logic [19:0] gap_q;   // cycles since cke rise or last mode write
  logic [3:0]  cmd_q;   // command one cycle ago
  logic [2:0]  last_q;  // last mode register written
  logic        cke_q;   // cke one cycle ago
  // a mode write stands a whole ck period, so only its first cycle counts
  wire mrs_go = (cmd_n == CMD_MRS) && (cmd_q != CMD_MRS);
  // helper counters
  always_ff @(posedge clock) begin
    cmd_q  <= rst_n ? cmd_n : CMD_NOP;
    cke_q  <= rst_n & cke;
    low_q  <= (!rst_n || reset_n) ? 20'h0 : low_q + 20'h1;
    wait_q <= (!rst_n || !reset_n) ? 20'h0 : wait_q + 20'h1;
    gap_q  <= (!rst_n || mrs_go || (cke && !cke_q)) ? 20'h0 : gap_q + 20'h1;
    if (mrs_go) begin
      last_q <= bank_select;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_reset_hold: assert property ($rose(reset_n) |-> low_q >= RST_SP_CYC)
    else $error("memory reset released too early");
  chk_cke_wait: assert property ($rose(cke) |-> wait_q >= CKE_WAIT_CYCLES)
    else $error("cke raised too early");
  chk_cke_nop: assert property ($rose(cke) |-> cmd_n inside {CMD_NOP, CMD_DES})
    else $error("no idle command before cke");
  chk_cke_held: assert property ($fell(cke) |-> ##[0:4] !reset_n)
    else $error("cke dropped outside reset");
  chk_term_off: assert property ((!cke) [*8] |-> term_hiz)
    else $error("termination on before cke");
  chk_term_low: assert property ($rose(cke) |-> (!termination_ctrl_in) [*8])
    else $error("termination control not held low");
  chk_mode_gap: assert property (mrs_go |-> gap_q >= MRD_TCK * 2 * CK_HALF)
    else $error("mode writes too close");
  chk_mode_bank: assert property (mrs_go |-> !bank_select[2])
    else $error("mode write bank bit two high");
  chk_mode_order: assert property (mrs_go && bank_select == MR_ZERO |-> last_q == MR_ONE)
    else $error("mode writes out of order");
  chk_dll_enable: assert property (mrs_go && bank_select == MR_ONE |-> !row_col_address[0])
    else $error("dll not enabled");
  chk_dll_restart: assert property (mrs_go && bank_select == MR_ZERO |-> row_col_address[8])
    else $error("dll restart missing");
  chk_cal_long: assert property (cmd_n == CMD_ZQ |-> row_col_address[10])
    else $error("calibration not long");
endmodule // lvsd_properties

// File: test/testbench.sv
// ****************************************
// both ends joined, user sides driven
// ****************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import lvsd_pkg::*;
  localparam int CKE_WAIT = 100;  // short cke wait keeps the run small
  logic clock = 0, rst_n = 0, soft_reset = 0, term_on = 1;
  logic req_valid = 0, req_auto_close = 0, req_chop = 0;
  logic [13:0] req_addr = 14'h0, mr1_val = 14'h0001, mr2_val = 14'h0, mr3_val = 14'h0;
  logic [13:0] mr0_val = 14'h0001;  // bursts chosen on the fly
  lvsd_op_t    req_op = OP_ACT;
  logic [2:0]  req_bank = 3'h0, burst_bank;
  logic        req_ready, init_done, dev_ready, dll_on, burst_active, burst_write;
  logic [7:0]  open_banks;
  logic [13:0] burst_row, burst_col;
  int          failures = 0, comparisons = 0, n;
  lvsd_if mem_if();
  // short waits keep the run small
  lvsd_ctrl #(.RST_PU_CYCLES(50), .CKE_WAIT_CYCLES(CKE_WAIT)) lvsd_ctrl_inst (.clock, .rst_n,
    .mem(mem_if), .soft_reset, .mr0_val, .mr1_val, .mr2_val, .mr3_val, .term_on, .req_valid,
    .req_op, .req_bank, .req_addr, .req_auto_close, .req_chop, .req_ready, .init_done);
  lvsd_dev lvsd_dev_inst (.clock, .rst_n, .mem(mem_if), .dev_ready, .dll_on, .open_banks,
    .burst_active, .burst_write, .burst_bank, .burst_row, .burst_col);
  lvsd_properties #(.CKE_WAIT_CYCLES(CKE_WAIT)) lvsd_properties_inst (.clock, .rst_n,
    .reset_n(mem_if.reset_n),
    .ck(mem_if.ck), .cke(mem_if.cke), .cmd_n(mem_if.cmd_n), .bank_select(mem_if.bank_select),
    .row_col_address(mem_if.row_col_address), .term_hiz(mem_if.term_hiz),
    .termination_ctrl_in(mem_if.termination_ctrl_in));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a bounded wait that ran out counts as a mismatch and ends the run
  task automatic give_up(input int lim);
    if (n >= lim) begin
      failures++;
      end_sim();
    end
  endtask
  // bounded wait for the whole init sequence
  task automatic wait_init;
    n = 0;
    while (init_done !== 1'b1 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    give_up(20000);
    repeat (20) @(posedge clock);
  endtask
  // one order, held until the edge that takes it
  task automatic issue(input lvsd_op_t op, input logic [13:0] a, input logic ac, input logic ch);
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_bank <= 3'h5;
    req_addr <= a;
    req_auto_close <= ac;
    req_chop <= ch;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    req_valid <= 1'b0;
    give_up(20);
    repeat (2) @(posedge clock);
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    give_up(20);
  endtask
  task automatic t_init;
    repeat (20) @(posedge clock);
    check(req_ready, 1'b0);
    check(mem_if.term_hiz, 1'b1);
    wait_init();
    check(dev_ready, 1'b1);
    check(dll_on, 1'b1);
    check(mem_if.term_hiz, 1'b0);
    check(mem_if.cke, 1'b1);
    check(mem_if.termination_ctrl_in, 1'b1);
    $display("init test done");
  endtask
  task automatic t_act;
    issue(OP_ACT, 14'h0634, 1'b0, 1'b0);
    repeat (20) @(posedge clock);
    check(open_banks, 8'h20);
    $display("activate test done");
  endtask
  task automatic t_burst(input lvsd_op_t op, input logic ac, input logic ch, input int beats);
    issue(op, 14'h0010, ac, ch);
    n = 0;
    while (burst_active !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    give_up(40);
    check(burst_col, 14'h0010);
    check({burst_bank, burst_row}, {3'h5, 14'h0634});
    check(burst_write, op == OP_WR);
    n = 0;
    while (burst_active === 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    give_up(100);
    check(n, beats * CK_HALF);
    repeat (2) @(posedge clock);
    check(open_banks, ac ? 8'h00 : 8'h20);
    $display("burst test done");
  endtask
  // stable-power reset with a bank still open
  task automatic t_soft;
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    repeat (4) @(posedge clock);
    check({init_done, mem_if.reset_n, mem_if.cke, mem_if.termination_ctrl_in}, 4'h0);
    repeat (4) @(posedge clock);
    check(open_banks, 8'h00);
    wait_init();
    check({dev_ready, dll_on}, 2'h3);
    $display("soft reset test done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_init();
    t_act();
    t_burst(OP_WR, 1'b0, 1'b1, 4);
    t_soft();
    t_act();
    t_burst(OP_RD, 1'b1, 1'b0, 8);
    end_sim();
  end
endmodule // testbench
